/* verilog/amc_pkg.sv */
// package for the amplifier mode and status control block
// assumes one clock domain (pclk) and an apb master of 32-bit data
package amc_pkg;
    // register byte offsets
    localparam logic [11:0] AMC_CFG_OFF = 12'h000;
    localparam logic [11:0] AMC_STAT_OFF = 12'h004;
    localparam logic [11:0] AMC_IRQ_STAT_OFF = 12'h008;
    localparam logic [11:0] AMC_IRQ_MASK_OFF = 12'h00C;
    // mode strap codes {bit2,bit1,bit0}
    localparam logic [2:0] AMC_MODE_2BTL_AD = 3'h0;
    localparam logic [2:0] AMC_MODE_2BTL_BD = 3'h2;
    localparam logic [2:0] AMC_MODE_BTL_2SE = 3'h3;
    localparam logic [2:0] AMC_MODE_4SE = 3'h4;
    localparam logic [2:0] AMC_MODE_PARALLEL_BRIDGE_LOAD = 3'h5;
    // decoded topology
    localparam logic [1:0] AMC_TOPO_BTL = 2'h0;
    localparam logic [1:0] AMC_TOPO_BTL_SE = 2'h1;
    localparam logic [1:0] AMC_TOPO_SE = 2'h2;
    localparam logic [1:0] AMC_TOPO_PARALLEL_BRIDGE_LOAD = 2'h3;
    // interrupt event bit positions
    localparam int AMC_EV_CLIP = 0;
    localparam int AMC_EV_OC = 1;
    localparam int AMC_EV_WARN_LO = 2;
    localparam int AMC_EV_WARN_HI = 3;
    localparam int AMC_EV_OTE = 4;
    localparam int AMC_EV_W = 5;
    // startup sequence length
    localparam int AMC_STARTUP_US = 10;
    localparam int AMC_CLK_MHZ = 250;
    localparam int AMC_STARTUP_CYC = AMC_STARTUP_US * AMC_CLK_MHZ;
    localparam logic [11:0] AMC_STARTUP_CNT = 12'(AMC_STARTUP_CYC - 1);
    typedef enum logic [1:0] {
        AMC_ST_IDLE = 2'b00,
        AMC_ST_START = 2'b01,
        AMC_ST_RUN = 2'b10,
        AMC_ST_OTE = 2'b11
    } amc_state_t;
endpackage

/* verilog/amc_ctrl.sv */
// amplifier mode and status control: straps, startup, status pins, apb regs
// assumes inputs synchronous to pclk and an apb master per the amba rules
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - decode the three mode straps into topology and modulation, 001/110/111 reserved.
// - in parallel-bridge mode input straps c,d pick two-level (00) or three-level (10).
// - on release of reset run the startup sequence, then start switching.
// - while reset is low all outputs are high impedance and no pwm switching.
// - ready goes high once running and low on any overcurrent event.
// - clip indicator follows the near-clipping detector while switching (run state only).
// - osc trim tied to the regulator rail disables the oscillator, osc pins become inputs.
// - two thermal warnings, the low one tripping before the high one.
// - while reset is low fault signalling is suppressed and fault_shutdown_n is high.
// - overtemperature in startup or run latches outputs off with fault low until reset is asserted.
//////////////////////////////////////////////////////////////////////////////
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module amc_ctrl
    import amc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mode_strap_bit0,
    input wire logic mode_strap_bit1,
    input wire logic mode_strap_bit2,
    input wire logic input_c_strap,
    input wire logic input_d_strap,
    input wire logic osc_trim_at_regulator,
    input wire logic clip_detect,
    input wire logic overcurrent_detect,
    input wire logic temp_above_low,
    input wire logic temp_above_high,
    input wire logic overtemp_detect,
    output logic osc_enable,
    output logic osc_pins_input,
    output logic pwm_enable,
    output logic outputs_oe,
    output logic three_level_modulation,
    output logic [1:0] topology,
    output logic mode_reserved,
    output logic ready_o,
    output logic ready_oe,
    output logic clip_n_o,
    output logic clip_n_oe,
    output logic fault_shutdown_n_o,
    output logic fault_shutdown_n_oe,
    output logic thermal_warn_low_n_o,
    output logic thermal_warn_low_n_oe,
    output logic thermal_warn_high_n_o,
    output logic thermal_warn_high_n_oe,
    output logic irq
);

    typedef struct packed {
        amc_state_t state;
        logic [11:0] cnt;
        logic sampled;
        logic [2:0] mode;
        logic cstrap;
        logic dstrap;
        logic slave_osc;
        logic ready;
        logic clip;
        logic warn_lo;
        logic warn_hi;
        logic [AMC_EV_W-1:0] ev;
        logic [AMC_EV_W-1:0] mask;
        logic sw_hold;
        logic [31:0] rdata;
    } amc_regs_t;

    amc_regs_t s_r, s_nxt;
    logic wr_acc, rd_acc;
    logic [AMC_EV_W-1:0] ev_set, w1c;
    logic three_lvl;
    logic [1:0] topo;
    logic rsvd;

    //////////////////////////////////////////////////////////////////////////
    // strap decode from latched values
    always_comb begin
        three_lvl = 1'b0;
        topo = AMC_TOPO_BTL;
        rsvd = 1'b0;
        case (s_r.mode)
            AMC_MODE_2BTL_AD: begin
                topo = AMC_TOPO_BTL;
            end
            AMC_MODE_2BTL_BD: begin
                topo = AMC_TOPO_BTL;
                three_lvl = 1'b1;
            end
            AMC_MODE_BTL_2SE: begin
                topo = AMC_TOPO_BTL_SE;
                three_lvl = 1'b1;
            end
            AMC_MODE_4SE: begin
                topo = AMC_TOPO_SE;
            end
            AMC_MODE_PARALLEL_BRIDGE_LOAD: begin
                topo = AMC_TOPO_PARALLEL_BRIDGE_LOAD;
                three_lvl = s_r.cstrap & ~s_r.dstrap;
                rsvd = s_r.dstrap;
            end
            default: begin
                rsvd = 1'b1;
            end
        endcase
    end

    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & ~penable & ~pwrite;
    assign w1c = (wr_acc && paddr == AMC_IRQ_STAT_OFF) ? pwdata[AMC_EV_W-1:0] : '0;

    //////////////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb begin
        s_nxt = s_r;
        ev_set = '0;
        // straps caught on the first edge after release
        if (!s_r.sampled) begin
            s_nxt.sampled = 1'b1;
            s_nxt.mode = {mode_strap_bit2, mode_strap_bit1, mode_strap_bit0};
            s_nxt.cstrap = input_c_strap;
            s_nxt.dstrap = input_d_strap;
            s_nxt.slave_osc = osc_trim_at_regulator;
        end
        s_nxt.clip = clip_detect & (s_r.state == AMC_ST_RUN);
        s_nxt.warn_lo = temp_above_low;
        s_nxt.warn_hi = temp_above_high & temp_above_low;
        case (s_r.state)
            AMC_ST_IDLE: begin
                if (s_r.sampled && !rsvd && !s_r.sw_hold) begin
                    s_nxt.state = AMC_ST_START;
                    s_nxt.cnt = '0;
                end
            end
            AMC_ST_START: begin
                s_nxt.cnt = s_r.cnt + 12'h001;
                if (s_r.cnt == AMC_STARTUP_CNT) begin
                    s_nxt.state = AMC_ST_RUN;
                end
            end
            AMC_ST_RUN: begin
                s_nxt.ready = ~overcurrent_detect;
                if (s_r.sw_hold) begin
                    s_nxt.state = AMC_ST_IDLE;
                    s_nxt.ready = 1'b0;
                end
            end
            AMC_ST_OTE: begin
                s_nxt.ready = 1'b0; // latched until reset
            end
            default: begin
                s_nxt.state = AMC_ST_IDLE;
            end
        endcase
        if (overtemp_detect && s_r.state != AMC_ST_IDLE) begin
            s_nxt.state = AMC_ST_OTE;
            s_nxt.ready = 1'b0;
        end
        // event capture, set wins over write-one-clear
        ev_set[AMC_EV_CLIP] = s_nxt.clip & ~s_r.clip;
        ev_set[AMC_EV_OC] = overcurrent_detect & (s_r.state == AMC_ST_RUN);
        ev_set[AMC_EV_WARN_LO] = s_nxt.warn_lo & ~s_r.warn_lo;
        ev_set[AMC_EV_WARN_HI] = s_nxt.warn_hi & ~s_r.warn_hi;
        ev_set[AMC_EV_OTE] = overtemp_detect & (s_r.state != AMC_ST_IDLE);
        s_nxt.ev = (s_r.ev & ~w1c) | ev_set;
        if (wr_acc && paddr == AMC_IRQ_MASK_OFF) begin
            s_nxt.mask = pwdata[AMC_EV_W-1:0];
        end
        if (wr_acc && paddr == AMC_CFG_OFF) begin
            s_nxt.sw_hold = pwdata[0];
        end
        if (rd_acc) begin
            case (paddr)
                AMC_CFG_OFF: s_nxt.rdata = {31'h0, s_r.sw_hold};
                AMC_STAT_OFF: s_nxt.rdata = {20'h0, s_r.slave_osc, rsvd, topo,
                    three_lvl, s_r.mode, s_r.ready, s_r.state, s_r.sampled};
                AMC_IRQ_STAT_OFF: s_nxt.rdata = {27'h0, s_r.ev};
                AMC_IRQ_MASK_OFF: s_nxt.rdata = {27'h0, s_r.mask};
                default: s_nxt.rdata = 32'h0;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // single state register, all cleared while reset is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // apb answer: zero wait, unmapped address reads zero with error
    assign pready = 1'b1;
    assign prdata = s_r.rdata;
    assign pslverr = psel & penable & (paddr != AMC_CFG_OFF) & (paddr != AMC_STAT_OFF)
        & (paddr != AMC_IRQ_STAT_OFF) & (paddr != AMC_IRQ_MASK_OFF);
    assign irq = |(s_r.ev & s_r.mask);

    //////////////////////////////////////////////////////////////////////////
    // pin drive, all released while in reset
    assign pwm_enable = (s_r.state == AMC_ST_RUN);
    assign outputs_oe = pwm_enable;
    assign osc_enable = s_r.sampled & ~s_r.slave_osc;
    assign osc_pins_input = s_r.slave_osc;
    assign three_level_modulation = three_lvl;
    assign topology = topo;
    assign mode_reserved = s_r.sampled & rsvd;
    assign ready_o = 1'b0;
    assign ready_oe = s_r.sampled & ~s_r.ready;
    assign clip_n_o = 1'b0;
    assign clip_n_oe = s_r.clip;
    assign fault_shutdown_n_o = 1'b0;
    // low only in overtemperature latch; released in reset
    assign fault_shutdown_n_oe = (s_r.state == AMC_ST_OTE);
    assign thermal_warn_low_n_o = 1'b0;
    assign thermal_warn_low_n_oe = s_r.warn_lo;
    assign thermal_warn_high_n_o = 1'b0;
    assign thermal_warn_high_n_oe = s_r.warn_hi;

    //////////////////////////////////////////////////////////////////////////
    // checks: sequences first, then one group per concern
    sequence start_enter_s;
        (s_r.state == AMC_ST_IDLE) ##1 (s_r.state == AMC_ST_START);
    endsequence

    sequence startup_s;
        (s_r.state == AMC_ST_START) ##1 (s_r.state == AMC_ST_START) [*2];
    endsequence

    // reset holds every pin released and switching off
    fault_in_reset_a: assert property (
        @(posedge pclk) !presetn |-> !fault_shutdown_n_oe)
        else $error("fault driven during reset");
    no_pwm_reset_a: assert property (
        @(posedge pclk) !presetn |-> !pwm_enable)
        else $error("switching during reset");
    pins_reset_a: assert property (
        @(posedge pclk) !presetn |-> !outputs_oe && !ready_oe && !clip_n_oe
        && !thermal_warn_low_n_oe && !thermal_warn_high_n_oe)
        else $error("pin driven during reset");

    // startup runs its full count before switching
    startup_first_a: assert property (
        @(posedge pclk) disable iff (!presetn) start_enter_s |-> !pwm_enable && s_r.cnt == '0)
        else $error("startup entered badly");
    startup_seq_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        startup_s |-> !pwm_enable && s_r.cnt == $past(s_r.cnt) + 12'h001)
        else $error("startup count stalls");
    start_len_a: assert property (
        @(posedge pclk) disable iff (!presetn) $rose(pwm_enable) |->
        $past(s_r.state) == AMC_ST_START && $past(s_r.cnt) == AMC_STARTUP_CNT)
        else $error("switching before full startup");
    hold_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_r.sw_hold && pwm_enable |=> !pwm_enable && ready_oe)
        else $error("software hold ignored");
    hold_stay_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_r.sw_hold && s_r.state == AMC_ST_IDLE |=> s_r.state == AMC_ST_IDLE)
        else $error("startup under software hold");

    // ready follows run state and overcurrent
    oc_ready_a: assert property (
        @(posedge pclk) disable iff (!presetn) overcurrent_detect && pwm_enable |=> ready_oe)
        else $error("ready stays high on overcurrent");
    ready_run_a: assert property (
        @(posedge pclk) disable iff (!presetn) pwm_enable && !overcurrent_detect
        && !overtemp_detect && !s_r.sw_hold |=> !ready_oe)
        else $error("ready not raised while running");
    ready_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_r.sampled && !pwm_enable |-> ready_oe)
        else $error("ready high while not running");
    ev_oc_a: assert property (
        @(posedge pclk) disable iff (!presetn) overcurrent_detect && pwm_enable |=> s_r.ev[AMC_EV_OC])
        else $error("overcurrent event lost");

    // overtemperature latch
    ote_latch_a: assert property (
        @(posedge pclk) disable iff (!presetn) fault_shutdown_n_oe |=> fault_shutdown_n_oe && !pwm_enable)
        else $error("overtemp latch released");
    ev_ote_a: assert property (
        @(posedge pclk) disable iff (!presetn) overtemp_detect && s_r.state != AMC_ST_IDLE
        |=> fault_shutdown_n_oe && s_r.ev[AMC_EV_OTE])
        else $error("overtemp not latched");
    ote_ready_a: assert property (
        @(posedge pclk) disable iff (!presetn) fault_shutdown_n_oe |-> ready_oe && !outputs_oe)
        else $error("outputs live in overtemp latch");

    // thermal warnings and clip
    warn_order_a: assert property (
        @(posedge pclk) disable iff (!presetn) thermal_warn_high_n_oe |-> thermal_warn_low_n_oe)
        else $error("high warning without low");
    warn_lo_a: assert property (
        @(posedge pclk) disable iff (!presetn) temp_above_low |=> thermal_warn_low_n_oe)
        else $error("low warning not flagged");
    warn_hi_a: assert property (
        @(posedge pclk) disable iff (!presetn) temp_above_high && temp_above_low |=> thermal_warn_high_n_oe)
        else $error("high warning not flagged");
    clip_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn) clip_detect && pwm_enable |=> clip_n_oe)
        else $error("clip not flagged");
    clip_off_a: assert property (
        @(posedge pclk) disable iff (!presetn) !pwm_enable |=> !clip_n_oe)
        else $error("clip flagged while idle");
    ev_clip_a: assert property (
        @(posedge pclk) disable iff (!presetn) clip_detect && pwm_enable && !clip_n_oe |=> s_r.ev[AMC_EV_CLIP])
        else $error("clip event lost");

    // strap decode and hold
    strap_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_r.sampled |=> $stable(s_r.mode) && $stable(s_r.cstrap))
        else $error("straps changed after sampling");
    strap_more_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_r.sampled |=> $stable(s_r.dstrap) && $stable(s_r.slave_osc))
        else $error("strap copy changed after sampling");
    parallel_bridge_load_mod_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_r.mode == AMC_MODE_PARALLEL_BRIDGE_LOAD && !s_r.cstrap |-> !three_level_modulation)
        else $error("parallel_bridge_load modulation wrong");
    parallel_bridge_load_three_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_r.mode == AMC_MODE_PARALLEL_BRIDGE_LOAD && s_r.cstrap && !s_r.dstrap
        |-> three_level_modulation && topology == AMC_TOPO_PARALLEL_BRIDGE_LOAD)
        else $error("parallel_bridge_load three-level wrong");
    rsvd_mode_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_r.mode == 3'h1 && s_r.sampled |-> mode_reserved && !pwm_enable)
        else $error("reserved mode runs");
    rsvd_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn) mode_reserved |-> s_r.state == AMC_ST_IDLE)
        else $error("reserved mode leaves idle");

    // oscillator master or slave
    osc_slave_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_r.slave_osc |-> !osc_enable && osc_pins_input)
        else $error("oscillator not slaved");
    osc_master_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_r.sampled && !s_r.slave_osc |-> osc_enable && !osc_pins_input)
        else $error("oscillator not master");

endmodule

/* tb/amc_host.sv */
// host side model: pull-ups on the fault and ready pins, reset pin driver, ready filter
// assumes one pclk domain; the bench requests resets through rst_req_n
`timescale 1ns/1ps
module amc_host #(
    parameter int HOLD_CYC = 40
) (
    input wire logic pclk,
    input wire logic rst_req_n,
    input wire logic fault_oe,
    input wire logic ready_oe,
    output logic presetn,
    output logic fault_pin,
    output logic ready_pin,
    output logic audio_ok
);
    int gap_r = HOLD_CYC;
    int rdy_cnt_r = 0;
    logic fault_d_r = 1'h1;
    initial presetn = 1'h0;
    //////////////////////////////////////////////////////////////////////////
    // pull-ups: a pin reads high unless the device sinks it
    assign fault_pin = ~fault_oe;
    assign ready_pin = ~ready_oe;
    // reset release waits a hold span after the fault pin fell
    always @(posedge pclk) begin
        fault_d_r <= fault_pin;
        if (fault_d_r && !fault_pin) gap_r <= 0;
        else if (gap_r < HOLD_CYC) gap_r <= gap_r + 1;
        if (!rst_req_n) presetn <= 1'h0;
        else if (gap_r >= HOLD_CYC) presetn <= 1'h1;
    end
    // audio only after ready stays high a few cycles
    always @(posedge pclk) begin
        rdy_cnt_r <= !ready_pin ? 0 : (rdy_cnt_r < 8) ? rdy_cnt_r + 1 : rdy_cnt_r;
    end
    assign audio_ok = (rdy_cnt_r == 8);
endmodule

/* tb/testbench.sv */
// self-checking bench for the amplifier mode and status control block
// assumes amc_pkg compiled first and the host model in amc_host
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    import amc_pkg::*;
    logic pclk = 1'h0;
    logic presetn, rst_req_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] mode;
    logic in_c, in_d, trim, clip, oc, t_lo, t_hi, overtemp_error_latch, osc_en, osc_in, pwm, oe, three, res;
    logic rdy_oe, clip_oe, flt_oe, wlo_oe, whi_oe, fault_pin, ready_pin, audio_ok;
    logic [1:0] topo;
    int miscompares, n_compared;
    always #2 pclk = ~pclk;
    //////////////////////////////////////////////////////////////////////////
    amc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_strap_bit0(mode[0]), .mode_strap_bit1(mode[1]),
        .mode_strap_bit2(mode[2]), .input_c_strap(in_c), .input_d_strap(in_d),
        .osc_trim_at_regulator(trim), .clip_detect(clip), .overcurrent_detect(oc),
        .temp_above_low(t_lo), .temp_above_high(t_hi), .overtemp_detect(overtemp_error_latch),
        .osc_enable(osc_en), .osc_pins_input(osc_in), .pwm_enable(pwm), .outputs_oe(oe),
        .three_level_modulation(three), .topology(topo), .mode_reserved(res),
        .ready_o(), .ready_oe(rdy_oe), .clip_n_o(), .clip_n_oe(clip_oe),
        .fault_shutdown_n_o(), .fault_shutdown_n_oe(flt_oe), .thermal_warn_low_n_o(),
        .thermal_warn_low_n_oe(wlo_oe), .thermal_warn_high_n_o(),
        .thermal_warn_high_n_oe(whi_oe), .irq(irq));
    amc_host #(.HOLD_CYC(40)) u_host (.pclk(pclk), .rst_req_n(rst_req_n),
        .fault_oe(flt_oe), .ready_oe(rdy_oe), .presetn(presetn), .fault_pin(fault_pin),
        .ready_pin(ready_pin), .audio_ok(audio_ok));
    //////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic clk(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask
    task automatic do_reset(input logic [2:0] m, input logic c, input logic d, input logic t);
        @(posedge pclk);
        rst_req_n <= 1'h0;
        clk(3);
        mode <= m; in_c <= c; in_d <= d; trim <= t; rst_req_n <= 1'h1;
        while (presetn !== 1'h1) @(posedge pclk);
    endtask
    function automatic logic [3:0] exp_cfg(input logic [2:0] m, input logic c, input logic d);
        case (m)
            AMC_MODE_2BTL_AD: return {2'h0, AMC_TOPO_BTL};
            AMC_MODE_2BTL_BD: return {2'h1, AMC_TOPO_BTL};
            AMC_MODE_BTL_2SE: return {2'h1, AMC_TOPO_BTL_SE};
            AMC_MODE_4SE: return {2'h0, AMC_TOPO_SE};
            AMC_MODE_PARALLEL_BRIDGE_LOAD: return {d, c, AMC_TOPO_PARALLEL_BRIDGE_LOAD};
            default: return 4'h8;
        endcase
    endfunction
    //////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic start_run;
        int n;
        n = 0;
        do_reset(3'h0, 1'h0, 1'h0, 1'h0);
        clk(2);
        `CHK(rdy_oe, 1'h1)
        while (pwm !== 1'h1 && n < 3000) begin @(posedge pclk); n++; end
        `CHK(n >= 2495 && n <= 2505, 1'h1)
        clk(2);
        `CHK(rdy_oe, 1'h0)
        `CHK(oe, 1'h1)
    endtask
    task automatic t_reset_hold;
        @(posedge pclk);
        rst_req_n <= 1'h0; overtemp_error_latch <= 1'h1; clip <= 1'h1;
        clk(3);
        `CHK(flt_oe, 1'h0)
        `CHK(oe, 1'h0)
        `CHK(pwm, 1'h0)
        `CHK(clip_oe, 1'h0)
        overtemp_error_latch <= 1'h0; clip <= 1'h0;
    endtask
    task automatic t_modes;
        logic [2:0] m;
        logic c, d;
        logic [3:0] e;
        for (int i = 0; i < 10; i++) begin
            m = (i < 8) ? 3'(i) : 3'h5;
            c = (i == 8);
            d = (i == 9);
            e = exp_cfg(m, c, d);
            do_reset(m, c, d, m[0]);
            clk(2);
            `CHK(res, e[3])
            if (!e[3]) `CHK(three, e[2])
            if (!e[3]) `CHK(topo, e[1:0])
            `CHK(osc_en, ~m[0])
            `CHK(osc_in, m[0])
            mode <= ~m; in_c <= ~c; trim <= ~m[0];
            clk(3);
            `CHK(res, e[3])
            `CHK(osc_in, m[0])
        end
    endtask
    task automatic t_overcurrent;
        apb(0, AMC_STAT_OFF, 32'h0);
        `CHK(rd[3:1], 3'h6)
        apb(1, AMC_IRQ_STAT_OFF, 32'h1F);
        apb(1, AMC_IRQ_MASK_OFF, 32'h2);
        oc <= 1'h1;
        clk(2);
        `CHK(rdy_oe, 1'h1)
        `CHK(ready_pin, 1'h0)
        `CHK(irq, 1'h1)
        apb(1, AMC_IRQ_MASK_OFF, 32'h0);
        oc <= 1'h0;
        clk(2);
        `CHK(irq, 1'h0)
        `CHK(rdy_oe, 1'h0)
        apb(0, AMC_IRQ_STAT_OFF, 32'h0);
        `CHK(rd, 32'h2)
        apb(1, AMC_IRQ_STAT_OFF, 32'h2);
        apb(0, AMC_IRQ_STAT_OFF, 32'h0);
        `CHK(rd, 32'h0)
        apb(0, 12'h010, 32'h0);
        `CHK({err, rd}, 33'h100000000)
    endtask
    task automatic t_hold;
        int n;
        n = 0;
        apb(1, AMC_CFG_OFF, 32'h1);
        clk(2);
        `CHK(oe, 1'h0)
        `CHK(rdy_oe, 1'h1)
        apb(0, AMC_STAT_OFF, 32'h0);
        `CHK(rd[2:0], 3'h1)
        apb(1, AMC_CFG_OFF, 32'h0);
        while (pwm !== 1'h1 && n < 3000) begin @(posedge pclk); n++; end
        `CHK(n, AMC_STARTUP_CYC + 2)
        `CHK(audio_ok, 1'h0)
        clk(12);
        `CHK(audio_ok, 1'h1)
    endtask
    task automatic t_status;
        @(posedge pclk);
        clip <= 1'h1; t_lo <= 1'h1;
        clk(2);
        `CHK(clip_oe, 1'h1)
        `CHK(wlo_oe, 1'h1)
        `CHK(whi_oe, 1'h0)
        t_hi <= 1'h1;
        clk(2);
        `CHK(whi_oe, 1'h1)
        clip <= 1'h0; t_lo <= 1'h0; t_hi <= 1'h0;
        clk(2);
        `CHK(clip_oe, 1'h0)
        `CHK(wlo_oe, 1'h0)
        apb(0, AMC_IRQ_STAT_OFF, 32'h0);
        `CHK(rd, 32'hD)
        apb(1, AMC_IRQ_STAT_OFF, 32'hD);
    endtask
    task automatic t_overtemp;
        @(posedge pclk);
        overtemp_error_latch <= 1'h1;
        clk(2);
        `CHK(flt_oe, 1'h1)
        `CHK(oe, 1'h0)
        `CHK(fault_pin, 1'h0)
        overtemp_error_latch <= 1'h0;
        clk(10);
        `CHK(flt_oe, 1'h1)
        `CHK(pwm, 1'h0)
        start_run();
        `CHK(flt_oe, 1'h0)
        `CHK(fault_pin, 1'h1)
    endtask
    //////////////////////////////////////////////////////////////////////////
    // verdict and run control
    task automatic wrap_up;
        if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; rst_req_n = 0;
        mode = 0; in_c = 0; in_d = 0; trim = 0; clip = 0; oc = 0; t_lo = 0; t_hi = 0; overtemp_error_latch = 0;
        miscompares = 0;
        n_compared = 0;
        clk(4);
        t_reset_hold();
        t_modes();
        start_run();
        t_overcurrent();
        t_hold();
        t_status();
        t_overtemp();
        wrap_up();
    end
    initial begin
        repeat (30000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end
endmodule
